// >>> rtl/pmsac_pkg.sv
// Purpose: Types for the management serial slave and alert logic
// Assumes: Constants come from pmsac_regs.svh
// Notes: Carriers group telemetry and link state
package pmsac_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ = 3'b100,
		ST_RACK = 3'b101,
		ST_HALT = 3'b110
	} pmsac_state_t;
	typedef struct packed {
		logic [15:0] vin;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] temp;
	} pmsac_tele_t;
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] en1_s;
		logic [2:0] en2_s;
		logic [2:0] sync_s;
		logic [2:0] current_balance_wire_s;
		logic [2:0] flt_s;
		logic scl_q;
		logic sda_q;
		logic sync_q;
		pmsac_state_t state;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rd;
		logic ara;
		logic [1:0] byte_n;
		logic [7:0] cmd;
		logic [15:0] rdata;
		logic [7:0] fault;
		logic [6:0] addr;
		logic [1:0] mode;
		logic strapped;
		logic sda_oe;
		logic alert_oe;
		logic pg1;
		logic pg2;
		logic run1;
		logic run2;
		logic current_balance_wire_oe;
		logic seen;
		logic halted;
		logic [15:0] sync_cnt;
		logic [15:0] sync_per;
	} pmsac_state_rec_t;
endpackage

// >>> rtl/pmsac_regs.svh
// Purpose: Constants for the management serial slave and alert logic
// Assumes: 40 MHz module clock
// Notes: Offsets are command codes of the monitoring set
`ifndef PMSAC_REGS_SVH
`define PMSAC_REGS_SVH
`define PMSAC_ARA_ADDR 7'h0c
`define PMSAC_BASE_ADDR 7'h20
`define PMSAC_CMD_CLEAR_FAULTS 8'h03
`define PMSAC_CMD_STATUS 8'h79
`define PMSAC_CMD_VIN 8'h88
`define PMSAC_CMD_VOUT 8'h8b
`define PMSAC_CMD_IOUT 8'h8c
`define PMSAC_CMD_TEMP 8'h8d
`define PMSAC_CMD_MODE 8'hd0
`define PMSAC_SYNC_BITS 3
`define PMSAC_FREQ_WIDTH 16
`endif

// >>> rtl/pmsac_top.sv
// Purpose: Serial management slave, fault alert and rail control pins
// Assumes: Pins sampled by CLOCK; SCL slower than CLOCK by far
// Notes: Telemetry arrives as digital words from the converter core
// Notes on behaviour
// (RULE1) Each rail power-good output shows only that rail's state, push-pull.
// (RULE2) Each rail has its own enable input that starts its regulation.
// (RULE3) The sync input sets the switching frequency by its measured period.
// (RULE4) The balance wire is a two-way single wire for sharing and talk.
// (RULE5) The bus address comes from the address strap, unique per module.
// (RULE6) The operating mode comes from the configuration strap.
// (RULE7) The device is an SMBus 2.0 slave and the host follows that revision.
// (RULE8) The alert line is pulled low while any configured fault is present.
// (RULE9) Input and output voltage, current, temperature and status are readable.
// (RULE10) The host answers an alert with an alert response read.
// (RULE11) The host repeats alert response reads while the line stays low.
// (RULE12) A broken command halts the link until a rail is disabled and enabled; the code leaves the halt only when both enables are low.
// (RULE13) For command-driven start the enable input is held at signal ground; the code runs each rail only while its enable is high.
// (RULE14) After answering the alert response the alert is released if clear.
`timescale 1ns/10ps
`include "pmsac_regs.svh"
module pmsac_top #(
	parameter int FAULT_BITS = 8
) (
	input wire logic CLOCK, // Module clock
	input wire logic RESETN, // Asynchronous reset, active low
	input wire logic SCL_IN, // Serial clock level
	input wire logic SDA_IN, // Serial data level
	output logic SDA_OUT, // Serial data drive value, always low
	output logic SDA_OE, // Serial data pull-down enable
	output logic ALERT_OUT, // Fault alert drive value, always low
	output logic ALERT_OE, // Fault alert pull-down enable
	input wire logic RAIL1_ENABLE_IN, // Rail 1 enable, active high
	input wire logic RAIL2_ENABLE_IN, // Rail 2 enable, active high
	input wire logic RAIL1_GOOD_IN, // Rail 1 regulation in window
	input wire logic RAIL2_GOOD_IN, // Rail 2 regulation in window
	output logic RAIL1_POWER_GOOD, // Rail 1 power-good
	output logic RAIL2_POWER_GOOD, // Rail 2 power-good
	output logic RAIL1_RUN, // Rail 1 regulation enable
	output logic RAIL2_RUN, // Rail 2 regulation enable
	input wire logic SYNC_IN, // Frequency sync clock
	output logic [15:0] SYNC_PERIOD, // Sync period in module clocks
	input wire logic CURRENT_BALANCE_WIRE_IN, // Balance wire level
	output logic CURRENT_BALANCE_WIRE_OUT, // Balance drive value, low
	output logic CURRENT_BALANCE_WIRE_OE, // Balance pull-down enable
	input wire logic CURRENT_BALANCE_WIRE_REQ, // Core asks to pull the balance wire
	output logic CURRENT_BALANCE_WIRE_SEEN, // Balance wire seen low
	input wire logic [2:0] ADDR_STRAP, // Address strap code
	input wire logic [1:0] CFG_STRAP, // Mode strap code
	output logic [1:0] MODE, // Latched operating mode
	input wire logic [FAULT_BITS-1:0] FAULT_IN, // Fault conditions
	input wire pmsac_pkg::pmsac_tele_t TELE, // Telemetry words
	output logic HALTED // Link halted after broken command
);
	// More than eight fault bits would not fit the status byte
	if (FAULT_BITS < 1 || FAULT_BITS > 8) begin
		$error("FAULT_BITS must be 1 to 8");
	end

	pmsac_pkg::pmsac_state_rec_t s_r, s_nxt;
	logic scl_ok, sda_ok, scl_rise, scl_fall, start_c, stop_c;
	logic [7:0] fault_now;
	logic en1_ok, en2_ok;

	// ==========================================================
	// Sampled levels
	// ==========================================================
	// Stable level: second and third stages agree
	always_comb begin
		scl_ok = s_r.scl_q;
		sda_ok = s_r.sda_q;
		if (s_r.scl_s[1] == s_r.scl_s[2])
			scl_ok = s_r.scl_s[2];
		if (s_r.sda_s[1] == s_r.sda_s[2])
			sda_ok = s_r.sda_s[2];
		// Enables keep their last agreed level while the stages differ
		en1_ok = s_r.run1;
		en2_ok = s_r.run2;
		if (s_r.en1_s[1] == s_r.en1_s[2])
			en1_ok = s_r.en1_s[2];
		if (s_r.en2_s[1] == s_r.en2_s[2])
			en2_ok = s_r.en2_s[2];
		scl_rise = scl_ok & ~s_r.scl_q;
		scl_fall = ~scl_ok & s_r.scl_q;
		start_c = scl_ok & s_r.scl_q & s_r.sda_q & ~sda_ok; // RULE7
		stop_c = scl_ok & s_r.scl_q & ~s_r.sda_q & sda_ok; // RULE7
		fault_now = 8'h00;
		fault_now[FAULT_BITS-1:0] = s_r.flt_s[2] ? FAULT_IN : '0;
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_s = {s_r.scl_s[1:0], SCL_IN};
		s_nxt.sda_s = {s_r.sda_s[1:0], SDA_IN};
		s_nxt.en1_s = {s_r.en1_s[1:0], RAIL1_ENABLE_IN};
		s_nxt.en2_s = {s_r.en2_s[1:0], RAIL2_ENABLE_IN};
		s_nxt.sync_s = {s_r.sync_s[1:0], SYNC_IN};
		s_nxt.current_balance_wire_s = {s_r.current_balance_wire_s[1:0], CURRENT_BALANCE_WIRE_IN};
		s_nxt.flt_s = {s_r.flt_s[1:0], 1'b1};
		s_nxt.scl_q = scl_ok;
		s_nxt.sda_q = sda_ok;

		// Straps caught once, after reset release
		if (!s_r.strapped) begin
			s_nxt.strapped = 1'b1;
			s_nxt.addr = `PMSAC_BASE_ADDR | {4'h0, ADDR_STRAP}; // RULE5
			s_nxt.mode = CFG_STRAP; // RULE6
		end

		s_nxt.run1 = en1_ok; // RULE2
		s_nxt.run2 = en2_ok; // RULE2
		s_nxt.pg1 = en1_ok & RAIL1_GOOD_IN; // RULE1
		s_nxt.pg2 = en2_ok & RAIL2_GOOD_IN; // RULE1
		s_nxt.current_balance_wire_oe = CURRENT_BALANCE_WIRE_REQ; // RULE4
		if (s_r.current_balance_wire_s[1] == s_r.current_balance_wire_s[2])
			s_nxt.seen = ~s_r.current_balance_wire_s[2]; // RULE4

		// Sync period measured between rising edges
		// The agreed level is kept so that one rise is counted once;
		// a stopped sync input leaves the last period, the count saturates
		if (s_r.sync_s[2] == s_r.sync_s[1])
			s_nxt.sync_q = s_r.sync_s[2];
		if (s_r.sync_s[2] == s_r.sync_s[1] && s_r.sync_s[2] &&
		    !s_r.sync_q) begin
			s_nxt.sync_per = s_r.sync_cnt; // RULE3
			s_nxt.sync_cnt = 16'h0001;
		end else if (s_r.sync_cnt != 16'hffff) begin
			s_nxt.sync_cnt = s_r.sync_cnt + 16'h0001;
		end

		// Sticky faults; set wins over clear
		s_nxt.fault = s_r.fault | fault_now; // RULE8

		// ==================================================
		// Serial slave
		// ==================================================
		// Bits are taken on sampled SCL edges, so SCL must stay in each
		// phase for well over three module clocks.
		unique case (s_r.state)
			pmsac_pkg::ST_IDLE: begin
				s_nxt.sda_oe = 1'b0;
			end
			pmsac_pkg::ST_ADDR: begin
				if (scl_rise) begin
					s_nxt.sh = {s_r.sh[6:0], sda_ok};
					s_nxt.bitc = s_r.bitc + 4'h1;
				end
				if (scl_fall && s_r.bitc == 4'h8) begin
					s_nxt.rd = s_r.sh[0];
					s_nxt.ara = s_r.sh[7:1] == `PMSAC_ARA_ADDR &&
					    s_r.sh[0] && s_r.fault != 8'h00; // RULE14
					if (s_r.sh[7:1] == s_r.addr || s_nxt.ara) begin
						s_nxt.state = pmsac_pkg::ST_ACK;
						s_nxt.sda_oe = 1'b1;
					end else begin
						s_nxt.state = pmsac_pkg::ST_IDLE;
					end
				end
			end
			pmsac_pkg::ST_ACK: begin
				if (scl_fall) begin
					s_nxt.bitc = 4'h0;
					if (s_r.rd) begin
						// Alert response returns the own address, low bit set
						s_nxt.state = pmsac_pkg::ST_READ;
						s_nxt.sh = s_r.ara ? {s_r.addr, 1'b1} :
						    (s_r.byte_n == 2'd0 ? s_r.rdata[7:0] :
						    s_r.rdata[15:8]);
						s_nxt.sda_oe = s_r.ara ? ~s_r.addr[6] :
						    ~s_nxt.sh[7];
					end else begin
						s_nxt.state = pmsac_pkg::ST_WRITE;
						s_nxt.sda_oe = 1'b0;
					end
				end
			end
			pmsac_pkg::ST_WRITE: begin
				if (scl_rise) begin
					s_nxt.sh = {s_r.sh[6:0], sda_ok};
					s_nxt.bitc = s_r.bitc + 4'h1;
				end
				if (scl_fall && s_r.bitc == 4'h8) begin
					s_nxt.cmd = s_r.sh;
					s_nxt.byte_n = 2'd0;
					s_nxt.state = pmsac_pkg::ST_ACK;
					s_nxt.sda_oe = 1'b1;
					unique case (s_r.sh) // RULE9
						`PMSAC_CMD_VIN: s_nxt.rdata = TELE.vin;
						`PMSAC_CMD_VOUT: s_nxt.rdata = TELE.vout;
						`PMSAC_CMD_IOUT: s_nxt.rdata = TELE.iout;
						`PMSAC_CMD_TEMP: s_nxt.rdata = TELE.temp;
						`PMSAC_CMD_STATUS: s_nxt.rdata = {8'h00, s_r.fault};
						`PMSAC_CMD_MODE: s_nxt.rdata = {14'h0000, s_r.mode};
						`PMSAC_CMD_CLEAR_FAULTS: begin
							s_nxt.rdata = 16'h0000;
							s_nxt.fault = fault_now;
						end
						default: s_nxt.rdata = 16'h0000;
					endcase
				end
			end
			pmsac_pkg::ST_READ: begin
				if (scl_rise)
					s_nxt.bitc = s_r.bitc + 4'h1;
				if (scl_fall) begin
					if (s_r.bitc == 4'h8) begin
						s_nxt.state = pmsac_pkg::ST_RACK;
						s_nxt.sda_oe = 1'b0;
					end else begin
						s_nxt.sh = {s_r.sh[6:0], 1'b0};
						s_nxt.sda_oe = ~s_r.sh[6];
					end
				end
			end
			pmsac_pkg::ST_RACK: begin
				if (scl_rise) begin
					if (s_r.ara)
						s_nxt.fault = fault_now; // RULE14
					s_nxt.byte_n = s_r.byte_n + 2'd1;
					s_nxt.state = sda_ok ? pmsac_pkg::ST_IDLE :
					    pmsac_pkg::ST_ACK;
					s_nxt.ara = 1'b0;
				end
			end
			pmsac_pkg::ST_HALT: begin
				s_nxt.sda_oe = 1'b0;
				if (!en1_ok && !en2_ok)
					s_nxt.state = pmsac_pkg::ST_IDLE; // RULE12
			end
			default: s_nxt.state = pmsac_pkg::ST_IDLE;
		endcase

		// Read-on-ack continues with the next byte
		if (s_r.state == pmsac_pkg::ST_RACK && scl_rise && !sda_ok)
			s_nxt.rd = 1'b1;

		// ==================================================
		// Broken command trap
		// ==================================================
		// Once halted the link ignores every condition until the rails
		// are switched off, which is the only way out for the host.
		if (s_r.state != pmsac_pkg::ST_HALT) begin
			if (start_c) begin
				// Restart mid-byte in a write is a broken command. The SCL rise that
				// opens a START or STOP is already counted as one bit, so
				// only two or more counted bits mark a broken byte.
				if (s_r.state == pmsac_pkg::ST_WRITE && s_r.bitc > 4'h1)
					s_nxt.state = pmsac_pkg::ST_HALT; // RULE12
				else
					s_nxt.state = pmsac_pkg::ST_ADDR;
				s_nxt.bitc = 4'h0;
				s_nxt.sda_oe = 1'b0;
			end else if (stop_c) begin
				if ((s_r.state == pmsac_pkg::ST_WRITE ||
				    s_r.state == pmsac_pkg::ST_ADDR) &&
				    s_r.bitc > 4'h1)
					s_nxt.state = pmsac_pkg::ST_HALT; // RULE12
				else
					s_nxt.state = pmsac_pkg::ST_IDLE;
				s_nxt.sda_oe = 1'b0;
			end
		end

		s_nxt.alert_oe = s_nxt.fault != 8'h00; // RULE8
		s_nxt.halted = s_nxt.state == pmsac_pkg::ST_HALT; // RULE12
	end

	// ==========================================================
	// State register
	// ==========================================================
	// Bus lines and the balance wire reset to their idle high level so
	// that release does not look like a START or a pulled wire.
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			s_r <= '{scl_s: 3'b111, sda_s: 3'b111, scl_q: 1'b1,
			    sda_q: 1'b1, current_balance_wire_s: 3'b111,
			    state: pmsac_pkg::ST_IDLE,
			    addr: `PMSAC_BASE_ADDR, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign SDA_OUT = 1'b0;
	assign SDA_OE = s_r.sda_oe;
	assign ALERT_OUT = 1'b0;
	assign ALERT_OE = s_r.alert_oe;
	assign RAIL1_POWER_GOOD = s_r.pg1;
	assign RAIL2_POWER_GOOD = s_r.pg2;
	assign RAIL1_RUN = s_r.run1;
	assign RAIL2_RUN = s_r.run2;
	assign SYNC_PERIOD = s_r.sync_per;
	assign CURRENT_BALANCE_WIRE_OUT = 1'b0;
	assign CURRENT_BALANCE_WIRE_OE = s_r.current_balance_wire_oe;
	assign CURRENT_BALANCE_WIRE_SEEN = s_r.seen;
	assign MODE = s_r.mode;
	assign HALTED = s_r.halted;
endmodule

// >>> verif/pmsac_host_model.sv
// Purpose: Serial bus host that drives the slave
// Assumes: 200 ns bus clock, pull-ups on both lines
// Notes: Data is sampled late in the high phase for sync margin
`timescale 1ns/10ps
module pmsac_host (
	output logic scl, // Bus clock level
	output logic sda_pull, // Host pulls data low
	input wire logic sda // Resolved data line
);
	localparam int Q = 50;
	// ====
	// Bus conditions, clock idle high between frames
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		scl = 1'b0;
		#Q sda_pull = !b;
		#Q scl = 1'b1;
		#(2*Q-5) r = sda;
		#5;
	endtask
	task automatic start();
		scl = 1'b0;
		#Q sda_pull = 1'b0;
		#Q scl = 1'b1;
		#(2*Q) sda_pull = 1'b1;
		#(2*Q);
	endtask
	task automatic stop();
		scl = 1'b0;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_pull = 1'b0;
		#(2*Q);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ai, ack);
	endtask
endmodule

// >>> verif/pmsac_top_assertions.sv
// Purpose: Port checks of the management slave
// Assumes: Bound to pmsac_top; pins settle within eight clocks
// Notes: Serial timing is judged by the bench
`timescale 1ns/10ps
module pmsac_chk #(
	parameter int FAULT_BITS = 8
) (
	input wire logic CLOCK, // Clock
	input wire logic RESETN, // Reset
	input wire logic SCL_IN, // Bus clock
	input wire logic SDA_OE, // Data pull
	input wire logic ALERT_OE, // Alert pull
	input wire logic RAIL1_ENABLE_IN, // En 1
	input wire logic RAIL2_ENABLE_IN, // En 2
	input wire logic RAIL1_POWER_GOOD, // Good 1
	input wire logic RAIL2_POWER_GOOD, // Good 2
	input wire logic RAIL1_RUN, // Run 1
	input wire logic RAIL2_RUN, // Run 2
	input wire logic CURRENT_BALANCE_WIRE_IN, // Wire
	input wire logic CURRENT_BALANCE_WIRE_OE, // Wire pull
	input wire logic CURRENT_BALANCE_WIRE_REQ, // Pull ask
	input wire logic CURRENT_BALANCE_WIRE_SEEN, // Wire low
	input wire logic [FAULT_BITS-1:0] FAULT_IN, // Faults
	input wire logic HALTED // Halt
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	// ====
	// Pin relations
	a_rail1_on: assert property (RAIL1_ENABLE_IN [*6] |-> RAIL1_RUN)
		else $error("rail 1 not running");
	a_rail1_off: assert property (!RAIL1_ENABLE_IN [*6] |->
		!RAIL1_RUN && !RAIL1_POWER_GOOD) else $error("rail 1 not off");
	a_rail2_off: assert property (!RAIL2_ENABLE_IN [*6] |->
		!RAIL2_RUN && !RAIL2_POWER_GOOD) else $error("rail 2 not off");
	// Faults are masked for three clocks after reset, hence the eight-clock grace
	a_fault_alert: assert property ((FAULT_IN != '0) [*8] |-> ALERT_OE)
		else $error("alert not pulled");
	a_current_balance_wire_drive: assert property (CURRENT_BALANCE_WIRE_REQ [*2] |->
		CURRENT_BALANCE_WIRE_OE) else $error("wire not pulled");
	a_current_balance_wire_seen: assert property ($stable(CURRENT_BALANCE_WIRE_IN) [*5]
		|-> CURRENT_BALANCE_WIRE_SEEN == !CURRENT_BALANCE_WIRE_IN) else $error("wire seen");
	a_halt_exit: assert property ((!RAIL1_ENABLE_IN &&
		!RAIL2_ENABLE_IN) [*6] |-> !HALTED) else $error("halt stays");
	// Drive changes land one clock after SCL was seen low
	a_ack_scl_low: assert property ($changed(SDA_OE) |->
		!$past(SCL_IN)) else $error("data moved with clock high");
	c_ack: cover property ($rose(SDA_OE));
	c_release: cover property ($fell(ALERT_OE));
	c_halt: cover property ($rose(HALTED));
endmodule
bind pmsac_top pmsac_chk #(.FAULT_BITS(FAULT_BITS)) chk_u (
	.CLOCK(CLOCK), .RESETN(RESETN), .SCL_IN(SCL_IN), .SDA_OE(SDA_OE),
	.ALERT_OE(ALERT_OE), .RAIL1_ENABLE_IN(RAIL1_ENABLE_IN),
	.RAIL2_ENABLE_IN(RAIL2_ENABLE_IN), .RAIL1_POWER_GOOD(RAIL1_POWER_GOOD),
	.RAIL2_POWER_GOOD(RAIL2_POWER_GOOD), .RAIL1_RUN(RAIL1_RUN),
	.RAIL2_RUN(RAIL2_RUN), .CURRENT_BALANCE_WIRE_IN(CURRENT_BALANCE_WIRE_IN),
	.CURRENT_BALANCE_WIRE_OE(CURRENT_BALANCE_WIRE_OE), .CURRENT_BALANCE_WIRE_REQ(CURRENT_BALANCE_WIRE_REQ),
	.CURRENT_BALANCE_WIRE_SEEN(CURRENT_BALANCE_WIRE_SEEN), .FAULT_IN(FAULT_IN), .HALTED(HALTED)
);

// >>> verif/test_pmbus_slave_alert_control.sv
// Purpose: Self-checking bench of the management slave
// Assumes: 40 MHz clock; host model makes the bus clock
// Notes: Expected values come from straps and driven words
`timescale 1ns/10ps
`include "pmsac_regs.svh"
module test_pmbus_slave_alert_control;
	logic clock = 1'b0, resetn = 1'b0, en1 = 1'b0, en2 = 1'b0, g1 = 1'b0;
	logic g2 = 1'b0, sync = 1'b0, sreq = 1'b0, opull = 1'b0, n, k;
	logic scl, hpull, sda_oe, alert_oe, pg1, pg2, run1, run2, bal_oe, seen;
	logic halted;
	logic [15:0] per, w;
	logic [15:0] tq [$];
	logic [7:0] q, fault = 8'h00;
	logic [7:0] cmds [6] = '{`PMSAC_CMD_VIN, `PMSAC_CMD_VOUT,
		`PMSAC_CMD_IOUT, `PMSAC_CMD_TEMP, `PMSAC_CMD_STATUS,
		`PMSAC_CMD_MODE};
	logic [6:0] addr;
	logic [2:0] astrap = 3'h0;
	logic [1:0] cstrap = 2'h0, mode;
	pmsac_pkg::pmsac_tele_t tele = '0;
	int num_errors = 0, samples_checked = 0;
	wire sda = !(hpull | sda_oe);
	wire bal_in = !(bal_oe | opull);
	always #12.5 clock = ~clock;
	always #500 sync = ~sync;
	pmsac_host host_u (.scl(scl), .sda_pull(hpull), .sda(sda));
	pmsac_top dut_u (
		.CLOCK(clock), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(), .SDA_OE(sda_oe), .ALERT_OUT(), .ALERT_OE(alert_oe),
		.RAIL1_ENABLE_IN(en1), .RAIL2_ENABLE_IN(en2), .RAIL1_GOOD_IN(g1),
		.RAIL2_GOOD_IN(g2), .RAIL1_POWER_GOOD(pg1), .RAIL2_POWER_GOOD(pg2),
		.RAIL1_RUN(run1), .RAIL2_RUN(run2), .SYNC_IN(sync),
		.SYNC_PERIOD(per), .CURRENT_BALANCE_WIRE_IN(bal_in),
		.CURRENT_BALANCE_WIRE_OUT(), .CURRENT_BALANCE_WIRE_OE(bal_oe),
		.CURRENT_BALANCE_WIRE_REQ(sreq), .CURRENT_BALANCE_WIRE_SEEN(seen), .ADDR_STRAP(astrap),
		.CFG_STRAP(cstrap), .MODE(mode), .FAULT_IN(fault), .TELE(tele),
		.HALTED(halted)
	);
	// ====
	// Checking and bus tasks
	task automatic chk(input logic [15:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d,
		output logic nak);
		logic [7:0] b;
		logic a;
		host_u.start();
		host_u.xfer({addr, 1'b0}, 1'b1, b, nak);
		host_u.xfer(c, 1'b1, b, a);
		host_u.start();
		host_u.xfer({addr, 1'b1}, 1'b1, b, a);
		host_u.xfer(8'hff, 1'b0, d[7:0], a);
		host_u.xfer(8'hff, 1'b1, d[15:8], a);
		host_u.stop();
	endtask
	task automatic wr(input logic [7:0] c, output logic nak);
		logic [7:0] b;
		logic a;
		host_u.start();
		host_u.xfer({addr, 1'b0}, 1'b1, b, nak);
		host_u.xfer(c, 1'b1, b, a);
		host_u.stop();
	endtask
	task automatic ara(output logic [7:0] d, output logic nak);
		logic a;
		host_u.start();
		host_u.xfer({`PMSAC_ARA_ADDR, 1'b1}, 1'b1, d, nak);
		host_u.xfer(8'hff, 1'b1, d, a);
		host_u.stop();
	endtask
	task automatic final_report();
		$display("num_errors %0d samples_checked %0d", num_errors,
			samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		num_errors++;
		final_report();
	end
	// ====
	// Scenarios
	initial begin
		void'($urandom(32'h71fd));
		astrap = 3'($urandom);
		cstrap = 2'($urandom);
		tele = {$urandom, $urandom};
		addr = `PMSAC_BASE_ADDR | {4'h0, astrap};
		repeat (20) @(negedge clock);
		resetn = 1'b1;
		repeat (4) @(negedge clock);
		chk(mode, cstrap, "mode");
		for (int i = 0; i < 8; i++) begin
			{g1, en1, en2} = i[2:0];
			g2 = !g1;
			repeat (8) @(negedge clock);
			chk({pg1, pg2, run1, run2}, {en1 & g1, en2 & g2, en1, en2}, "rail");
		end
		chk(per, 16'h0028, "sync");
		for (int i = 0; i < 4; i++) begin
			{sreq, opull} = i[1:0];
			repeat (8) @(negedge clock);
			chk({bal_oe, seen}, {sreq, sreq | opull}, "current_balance_wire");
		end
		// Status reads zero with no fault, mode reads the strap
		tq = '{tele.vin, tele.vout, tele.iout, tele.temp, 16'h0000,
			{14'h0000, cstrap}};
		foreach (cmds[i]) begin
			rd(cmds[i], w, n);
			chk(n, 1'b0, "ack");
			chk(w, tq.pop_front(), "read word");
		end
		addr = addr ^ 7'h01;
		rd(`PMSAC_CMD_VIN, w, n);
		chk(n, 1'b1, "foreign address");
		addr = addr ^ 7'h01;
		@(negedge clock) fault = 8'h01 << ($urandom % 8);
		repeat (10) @(negedge clock);
		chk(alert_oe, 1'b1, "alert");
		// First response with the fault still present, then after it clears
		for (int i = 0; i < 2; i++) begin
			ara(q, n);
			chk({n, q}, {1'b0, addr, 1'b1}, "response");
			@(negedge clock) fault = 8'h00;
			repeat (4) @(negedge clock);
			chk(alert_oe, i == 0, "release");
		end
		// A fault that went away stays in status until cleared
		fault = 8'h80 >> ($urandom % 8);
		repeat (10) @(negedge clock);
		q = fault;
		fault = 8'h00;
		rd(`PMSAC_CMD_STATUS, w, n);
		chk(w, {8'h00, q}, "sticky status");
		wr(`PMSAC_CMD_CLEAR_FAULTS, n);
		repeat (4) @(negedge clock);
		chk({n, alert_oe}, 2'b00, "clear faults");
		host_u.start();
		host_u.xfer({addr, 1'b0}, 1'b1, q, n);
		repeat (3) host_u.bit_io(1'b1, k);
		host_u.stop();
		rd(`PMSAC_CMD_VIN, w, n);
		chk({halted, n}, 2'b11, "halt");
		@(negedge clock) {en1, en2} = 2'b00;
		repeat (8) @(negedge clock);
		{en1, en2} = 2'b11;
		rd(`PMSAC_CMD_VOUT, w, n);
		chk({halted, n}, 2'b00, "resume");
		chk(w, tele.vout, "resume data");
		final_report();
	end
endmodule
